//--- duart_top.sv
// Purpose: two serial ports with three 16-bit timers, timers 1 and 2 as bit-rate sources, APB registers
// Assumes: one clock, asynchronous active-low reset
// Notes: mode 0 codes are reserved and keep the port idle
// Operation
// - two ports, modes 1 to 3 only
// - mode 2 rate from fixed clock division
// - modes 1 and 3 use timer overflow
// - mode 1 frame: start, eight lsb-first, stop
// - mode 1 rate follows selected timer
// - port clock sixteen times bit rate
// - timer 1 to port zero, timer 2 to one
// - rate timers auto-reload sixteen bits on overflow
// - three 16-bit timers, third counts up/down
// - default rate 4800 bits per second on port zero; timer 2 is stopped at reset
// - timers measure, count, interrupt, drive waveforms
// - timer pins 0 to 2 feed timer count inputs, pin 3 unused
`timescale 1ns/100ps
`include "duart_map.svh"
module duart_top
  import duart_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] serialRxIn,
  output logic [1:0] serialTxOut,
  input wire logic [3:0] timerPinIn,
  output logic [2:0] timerWaveOut,
  output logic irq
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] syncA;
  logic [5:0] syncB;
  logic [3:0] pinPrev;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 6'h3F;
      syncB <= 6'h3F;
      // low, but syncB resets high, so a pin already low at release still gives one falling edge
      pinPrev <= 4'h0;
    end else begin
      syncA <= {timerPinIn, serialRxIn};
      syncB <= syncA;
      pinPrev <= syncB[5:2];
    end
  end
  wire logic [1:0] rxLine = syncB[1:0];
  wire logic [3:0] pinLvl = syncB[5:2];
  // timer2_external_control_in is pin 2; falling edges count events
  wire logic [3:0] pinFall = pinPrev & ~pinLvl;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [4:0] portCtrl [2];
  logic [11:0] tcon;
  logic [15:0] reload [3];
  logic [15:0] tcnt [3];
  logic [15:0] cmp [3];
  logic [`DU_ST_W-1:0] stat;
  logic [`DU_ST_W-1:0] mask;
  logic [8:0] rxData [2];
  logic [`DU_ST_W-1:0] evt;
  logic [1:0] txLoad;
  logic [2:0] tcntWr;
  logic [2:0] ovf;
  wire logic wrEn = psel & penable & pwrite;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  function automatic logic known(input logic [11:0] a);
    known = (a <= `DU_OFS_CMP2) && (a[1:0] == 2'b00);
  endfunction : known

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      portCtrl[0] <= `DU_CTRL_RST;
      portCtrl[1] <= `DU_CTRL_RST;
      tcon <= `DU_TCON_RST;
      mask <= '0;
      for (int i = 0; i < 3; i++) begin
        reload[i] <= `DU_RELOAD_RST;
        cmp[i] <= 16'h0000;
      end
    end else if (wrEn) begin
      if (hit(paddr, `DU_OFS_CTRL0)) portCtrl[0] <= pwdata[4:0];
      if (hit(paddr, `DU_OFS_CTRL1)) portCtrl[1] <= pwdata[4:0];
      if (hit(paddr, `DU_OFS_TCON)) tcon <= pwdata[11:0];
      if (hit(paddr, `DU_OFS_MASK)) mask <= pwdata[`DU_ST_W-1:0];
      if (hit(paddr, `DU_OFS_TRL0)) reload[0] <= pwdata[15:0];
      if (hit(paddr, `DU_OFS_TRL1)) reload[1] <= pwdata[15:0];
      if (hit(paddr, `DU_OFS_TRL2)) reload[2] <= pwdata[15:0];
      if (hit(paddr, `DU_OFS_CMP0)) cmp[0] <= pwdata[15:0];
      if (hit(paddr, `DU_OFS_CMP1)) cmp[1] <= pwdata[15:0];
      if (hit(paddr, `DU_OFS_CMP2)) cmp[2] <= pwdata[15:0];
    end
  end
  assign txLoad = {wrEn & hit(paddr, `DU_OFS_TXD1), wrEn & hit(paddr, `DU_OFS_TXD0)};
  assign tcntWr = {wrEn & hit(paddr, `DU_OFS_TCNT2), wrEn & hit(paddr, `DU_OFS_TCNT1),
                   wrEn & hit(paddr, `DU_OFS_TCNT0)};

  // ----------------------------------------
  // status and interrupt
  // ----------------------------------------
  // sticky status: a new event wins over a write-one clear in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stat <= '0;
    end else begin
      stat <= (stat & ~((wrEn && hit(paddr, `DU_OFS_STAT)) ? pwdata[`DU_ST_W-1:0] : '0)) | evt;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat & mask);
    end
  end

  // ----------------------------------------
  // bus read path
  // ----------------------------------------
  // single-cycle access phase: pready always high, unmapped reads zero with pslverr
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      pslverr <= psel & ~penable & ~known(paddr);
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `DU_OFS_CTRL0: prdata <= {27'h0, portCtrl[0]};
          `DU_OFS_CTRL1: prdata <= {27'h0, portCtrl[1]};
          `DU_OFS_RXD0: prdata <= {23'h0, rxData[0]};
          `DU_OFS_RXD1: prdata <= {23'h0, rxData[1]};
          `DU_OFS_STAT: prdata <= {23'h0, stat};
          `DU_OFS_MASK: prdata <= {23'h0, mask};
          `DU_OFS_TCON: prdata <= {20'h0, tcon};
          `DU_OFS_TRL0: prdata <= {16'h0, reload[0]};
          `DU_OFS_TRL1: prdata <= {16'h0, reload[1]};
          `DU_OFS_TRL2: prdata <= {16'h0, reload[2]};
          `DU_OFS_TCNT0: prdata <= {16'h0, tcnt[0]};
          `DU_OFS_TCNT1: prdata <= {16'h0, tcnt[1]};
          `DU_OFS_TCNT2: prdata <= {16'h0, tcnt[2]};
          `DU_OFS_CMP0: prdata <= {16'h0, cmp[0]};
          `DU_OFS_CMP1: prdata <= {16'h0, cmp[1]};
          `DU_OFS_CMP2: prdata <= {16'h0, cmp[2]};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // timers
  // ----------------------------------------
  // one ordinary reload counter shape for all three; only timer 2 honours the down bit
  for (genvar n = 0; n < 3; n++) begin : gTimer
    wire logic run = tcon[4*n+`DU_TCON_RUN];
    wire logic ext = tcon[4*n+`DU_TCON_EXT];
    wire logic gate = tcon[4*n+`DU_TCON_GATE];
    wire logic down = (n == 2) && tcon[4*n+`DU_TCON_DOWN];
    // gate lets a pin level measure pulse width; ext counts pin edges
    wire logic tick = run & (~gate | pinLvl[n]) & (ext ? pinFall[n] : 1'b1);
    wire logic wrap = tick & (down ? (tcnt[n] == reload[n]) : (tcnt[n] == 16'hFFFF));
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        tcnt[n] <= 16'h0000;
        ovf[n] <= 1'b0;
        evt[`DU_ST_OVF+n] <= 1'b0;
        timerWaveOut[n] <= 1'b0;
      end else begin
        ovf[n] <= wrap;
        evt[`DU_ST_OVF+n] <= wrap;
        timerWaveOut[n] <= (tcnt[n] >= cmp[n]);
        if (tcntWr[n]) begin
          tcnt[n] <= pwdata[15:0];
        end else if (wrap) begin
          tcnt[n] <= down ? 16'hFFFF : reload[n];
        end else if (tick) begin
          tcnt[n] <= down ? tcnt[n] - 16'h0001 : tcnt[n] + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // serial ports
  // ----------------------------------------
  // mode 2 divider free-runs, so the start bit may be up to one tick short
  logic [4:0] fixDiv;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      fixDiv <= 5'h00;
    end else begin
      fixDiv <= fixDiv + 5'h01;
    end
  end
  wire logic fixTick = (fixDiv == 5'(`DU_MODE2_DIV - 1));

  for (genvar p = 0; p < 2; p++) begin : gPort
    duart_mode_e mode;
    assign mode = duart_mode_e'(portCtrl[p][1:0]);
    wire logic live = (mode != DUART_MODE_RSVD);
    // default source: timer 1 for port zero, timer 2 for port one; src bit swaps to the other
    wire logic srcT = portCtrl[p][`DU_CTRL_SRC] ? ovf[2-p] : ovf[p+1];
    wire logic ovs = (mode == DUART_MODE_9FIX) ? fixTick : srcT;
    wire logic nine = (mode != DUART_MODE_8BIT);
    wire logic [3:0] nbits = nine ? 4'd9 : 4'd8;

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    duart_state_e txSt;
    logic [3:0] txPh;
    logic [3:0] txCnt;
    logic [8:0] txSh;
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        txSt <= DUART_IDLE;
        txPh <= 4'h0;
        txCnt <= 4'h0;
        txSh <= 9'h000;
        serialTxOut[p] <= 1'b1;
        evt[`DU_ST_TX+2*p] <= 1'b0;
      end else begin
        evt[`DU_ST_TX+2*p] <= 1'b0;
        if (ovs && txSt != DUART_IDLE) txPh <= txPh + 4'h1;
        case (txSt)
          DUART_IDLE: begin
            serialTxOut[p] <= 1'b1;
            if (txLoad[p] && live) begin
              txSh <= {portCtrl[p][`DU_CTRL_TB8] & nine, pwdata[7:0]};
              txPh <= 4'h0;
              txCnt <= 4'h0;
              txSt <= DUART_START;
            end
          end
          DUART_START: begin
            serialTxOut[p] <= 1'b0;
            if (ovs && txPh == `DU_LAST_TICK) txSt <= DUART_DATA;
          end
          DUART_DATA: begin
            serialTxOut[p] <= txSh[0];
            if (ovs && txPh == `DU_LAST_TICK) begin
              txSh <= {1'b0, txSh[8:1]};
              txCnt <= txCnt + 4'h1;
              if (txCnt == nbits - 4'h1) txSt <= DUART_STOP;
            end
          end
          DUART_STOP: begin
            serialTxOut[p] <= 1'b1;
            if (ovs && txPh == `DU_LAST_TICK) begin
              txSt <= DUART_IDLE;
              evt[`DU_ST_TX+2*p] <= 1'b1;
            end
          end
          default: txSt <= DUART_IDLE;
        endcase
      end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    // phase free-runs while idle; the start edge realigns it
    duart_state_e rxSt;
    logic [3:0] rxPh;
    logic [3:0] rxCnt;
    logic [8:0] rxSh;
    logic rxPrev;
    wire logic rxEn = live & portCtrl[p][`DU_CTRL_RXEN];
    wire logic mid = ovs && rxPh == `DU_SAMPLE;
    always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
        rxSt <= DUART_IDLE;
        rxPh <= 4'h0;
        rxCnt <= 4'h0;
        rxSh <= 9'h000;
        rxPrev <= 1'b1;
        rxData[p] <= 9'h000;
        evt[`DU_ST_RX+2*p] <= 1'b0;
        evt[`DU_ST_FE+p] <= 1'b0;
      end else begin
        rxPrev <= rxLine[p];
        evt[`DU_ST_RX+2*p] <= 1'b0;
        evt[`DU_ST_FE+p] <= 1'b0;
        if (ovs) rxPh <= rxPh + 4'h1;
        case (rxSt)
          DUART_IDLE: begin
            if (rxEn && rxPrev && !rxLine[p]) begin
              rxPh <= 4'h0;
              rxCnt <= 4'h0;
              rxSt <= DUART_START;
            end
          end
          DUART_START: begin
            // a glitch shorter than half a bit is dropped
            if (mid) rxSt <= rxLine[p] ? DUART_IDLE : DUART_DATA;
          end
          DUART_DATA: begin
            if (mid) begin
              rxSh <= nine ? {rxLine[p], rxSh[8:1]} : {1'b0, rxLine[p], rxSh[7:1]};
              rxCnt <= rxCnt + 4'h1;
              if (rxCnt == nbits - 4'h1) rxSt <= DUART_STOP;
            end
          end
          DUART_STOP: begin
            if (mid) begin
              rxData[p] <= rxSh;
              evt[`DU_ST_RX+2*p] <= 1'b1;
              evt[`DU_ST_FE+p] <= ~rxLine[p];
              rxSt <= DUART_IDLE;
            end
          end
          default: rxSt <= DUART_IDLE;
        endcase
      end
    end
  end

endmodule : duart_top

//--- duart_map.svh
// Purpose: register offsets, field positions, reset values and timing counts of the dual serial port block
// Assumes: 32-bit APB, one aligned word per register
// Notes: definitions only
`ifndef DUART_MAP_SVH
`define DUART_MAP_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define DU_OFS_CTRL0 12'h000
`define DU_OFS_CTRL1 12'h004
`define DU_OFS_TXD0 12'h008
`define DU_OFS_TXD1 12'h00C
`define DU_OFS_RXD0 12'h010
`define DU_OFS_RXD1 12'h014
`define DU_OFS_STAT 12'h018
`define DU_OFS_MASK 12'h01C
`define DU_OFS_TCON 12'h020
`define DU_OFS_TRL0 12'h024
`define DU_OFS_TRL1 12'h028
`define DU_OFS_TRL2 12'h02C
`define DU_OFS_TCNT0 12'h030
`define DU_OFS_TCNT1 12'h034
`define DU_OFS_TCNT2 12'h038
`define DU_OFS_CMP0 12'h03C
`define DU_OFS_CMP1 12'h040
`define DU_OFS_CMP2 12'h044
// ----------------------------------------
// port control fields: [1:0] mode, [2] rx enable, [3] rate source, [4] ninth tx bit
// ----------------------------------------
`define DU_CTRL_RXEN 2
`define DU_CTRL_SRC 3
`define DU_CTRL_TB8 4
// ----------------------------------------
// timer control fields, per timer n at base 4*n: run, external count, gate, down
// ----------------------------------------
`define DU_TCON_RUN 0
`define DU_TCON_EXT 1
`define DU_TCON_GATE 2
`define DU_TCON_DOWN 3
// ----------------------------------------
// status bits: per port p: tx done 2p, rx done 2p+1, frame err 4+p; timer n overflow 6+n
// ----------------------------------------
`define DU_ST_TX 0
`define DU_ST_RX 1
`define DU_ST_FE 4
`define DU_ST_OVF 6
`define DU_ST_W 9
// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define DU_CTRL_RST 5'h05
`define DU_TCON_RST 12'h011
`define DU_CLK_HZ 125000000
`define DU_BAUD 4800
`define DU_OVS 16
// reload for 4800 bit/s with 16 overflows per bit: 65536 - 125e6/(16*4800)
`define DU_RELOAD_RST 16'hF9A4
`define DU_MODE2_DIV 32
`define DU_SAMPLE 7
`define DU_LAST_TICK 15
`endif

//--- duart_pkg.sv
// Purpose: types shared by the dual serial port block
// Assumes: nothing
// Notes: none
package duart_pkg;
  typedef enum logic [1:0] {
    DUART_MODE_RSVD = 2'h0,
    DUART_MODE_8BIT = 2'h1,
    DUART_MODE_9FIX = 2'h2,
    DUART_MODE_9VAR = 2'h3
  } duart_mode_e;
  typedef enum logic [1:0] {
    DUART_IDLE = 2'b00,
    DUART_START = 2'b01,
    DUART_DATA = 2'b11,
    DUART_STOP = 2'b10
  } duart_state_e;
endpackage : duart_pkg

//--- duart_assertions.sv
// Purpose: port-level checks of the dual serial block
// Assumes: one clock, reset_n asynchronous active low
// Notes: a bit cell is 16 ticks, so never shorter than 16 cycles
`timescale 1ns/100ps
`include "duart_map.svh"
module duart_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] serialRxIn,
  input wire logic [1:0] serialTxOut,
  input wire logic [3:0] timerPinIn,
  input wire logic [2:0] timerWaveOut,
  input wire logic irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_mask_off;
    psel && penable && pwrite && paddr == `DU_OFS_MASK && pwdata[8:0] == 9'h000;
  endsequence
  sequence s_out_of_reset;
    $rose(reset_n);
  endsequence
  property p_tx0_cell; $changed(serialTxOut[0]) |=> $stable(serialTxOut[0])[*7]; endproperty
  property p_tx1_cell; $changed(serialTxOut[1]) |=> $stable(serialTxOut[1])[*7]; endproperty
  property p_tx0_start; $fell(serialTxOut[0]) |-> !serialTxOut[0] [*8]; endproperty
  property p_tx1_start; $fell(serialTxOut[1]) |-> !serialTxOut[1] [*8]; endproperty
  property p_irq_off; s_mask_off |-> ##[1:2] !irq; endproperty
  property p_wave_rst; s_out_of_reset |-> timerWaveOut == 3'h0; endproperty
  property p_idle_rst; s_out_of_reset |-> serialTxOut == 2'h3 && !irq; endproperty
  property p_ready; $past(reset_n) |-> pready; endproperty
  a_tx0_cell: assert property (p_tx0_cell) else $error("tx0 cell short");
  a_tx1_cell: assert property (p_tx1_cell) else $error("tx1 cell short");
  a_tx0_start: assert property (p_tx0_start) else $error("tx0 low too short");
  a_tx1_start: assert property (p_tx1_start) else $error("tx1 low too short");
  a_irq_off: assert property (p_irq_off) else $error("irq stays with mask off");
  a_wave_rst: assert property (p_wave_rst) else $error("wave not low at reset");
  a_idle_rst: assert property (p_idle_rst) else $error("lines not idle at reset");
  a_ready: assert property (p_ready) else $error("pready low");
endmodule : duart_assertions
bind duart_top duart_assertions u_duart_assertions (.*);

//--- duart_host.sv
// Purpose: far-side serial equipment for one port
// Assumes: bit time given in sys_clk cycles
// Notes: line held high between characters
`timescale 1ns/100ps
module duart_host (
  input wire logic sys_clk,
  input wire logic txLine,
  input wire logic [15:0] bitCyc,
  input wire logic [3:0] nSlots,
  output logic rxLine,
  output logic gotPulse,
  output logic [9:0] gotData
);
  initial begin
    rxLine = 1'b1;
    gotPulse = 1'b0;
    gotData = 10'h000;
  end
  // sample cell centres after the start edge; the stop bit lands last
  always begin : rx_frame
    @(negedge txLine);
    repeat (bitCyc / 2) @(posedge sys_clk);
    gotData <= 10'h000;
    for (int i = 0; i < nSlots; i++) begin
      repeat (bitCyc) @(posedge sys_clk);
      gotData[i] <= txLine;
    end
    gotPulse <= 1'b1;
    @(posedge sys_clk);
    gotPulse <= 1'b0;
  end
  task send(input logic [9:0] bits, input int n);
    @(posedge sys_clk);
    rxLine <= 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (bitCyc) @(posedge sys_clk);
      rxLine <= (i == n) ? 1'b1 : bits[i];
    end
  endtask : send
endmodule : duart_host

//--- tb_dual_uart_with_baud_timers.sv
// Purpose: self-checking bench of the dual serial block
// Assumes: 125 MHz clock, fast timer reloads keep frames short
// Notes: frames and reads are checked from queues
`timescale 1ns/100ps
`include "duart_map.svh"
module tb_dual_uart_with_baud_timers;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] serialRxIn, serialTxOut, gotPulse;
  logic [3:0] timerPinIn, nSlots;
  logic [2:0] timerWaveOut;
  logic [9:0] gotData [2];
  logic [15:0] bitCyc;
  logic [31:0] seed = 32'h0000_0037;
  logic [63:0] rdQ [$];
  logic [31:0] frQ [$];
  int errorCnt = 0;
  int testsRun = 0;
  duart_top u_duart_top (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serialRxIn(serialRxIn), .serialTxOut(serialTxOut),
    .timerPinIn(timerPinIn), .timerWaveOut(timerWaveOut), .irq(irq));
  duart_host u_host0 (.sys_clk(sys_clk), .txLine(serialTxOut[0]), .bitCyc(bitCyc), .nSlots(nSlots),
    .rxLine(serialRxIn[0]), .gotPulse(gotPulse[0]), .gotData(gotData[0]));
  duart_host u_host1 (.sys_clk(sys_clk), .txLine(serialTxOut[1]), .bitCyc(bitCyc), .nSlots(nSlots),
    .rxLine(serialRxIn[1]), .gotPulse(gotPulse[1]), .gotData(gotData[1]));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wrapUp();
    $display("mismatches %0d checks %0d", errorCnt, testsRun);
    if (errorCnt == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrapUp
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      errorCnt++;
      wrapUp();
    end
  endtask : apb
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rdQ.push_back({m, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd
  task waitIrq(input logic lvl);
    int n;
    n = 0;
    repeat (3) @(posedge sys_clk);
    while (irq !== lvl && n < 20000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 20000) begin
      errorCnt++;
      wrapUp();
    end
  endtask : waitIrq
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge sys_clk) begin
    logic [63:0] q;
    timerPinIn <= timerPinIn + 4'h1;
    if (psel && penable && pready && !pwrite) begin
      q = rdQ.pop_front();
      chk(prdata & q[63:32], q[31:0]);
      chk({31'h0, pslverr}, {31'h0, paddr > `DU_OFS_CMP2});
    end
    if (|gotPulse) chk({22'h0, gotData[gotPulse[1]]}, frQ.pop_front());
  end
  initial begin
    logic [31:0] r;
    logic [9:0] f;
    int p, m;
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    timerPinIn = 4'h0;
    bitCyc = 16'h0040;
    nSlots = 4'h9;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`DU_OFS_CTRL0, '1, 32'h0000_0005);
    rd(`DU_OFS_TCON, '1, 32'h0000_0011);
    rd(`DU_OFS_TRL1, '1, 32'h0000_F9A4);
    rd(12'h048, '1, 32'h0000_0000);
    apb(1'b1, `DU_OFS_TCON, 32'h0000_0111);
    for (p = 0; p < 3; p++) begin
      apb(1'b1, `DU_OFS_TRL0 + 12'(4 * p), (p == 2) ? 32'h0000_FFF8 : 32'h0000_FFFC);
      apb(1'b1, `DU_OFS_TCNT0 + 12'(4 * p), 32'h0000_FFF0);
    end
    apb(1'b1, `DU_OFS_MASK, 32'h0000_003F);
    for (p = 0; p < 2; p++) begin
      for (m = 1; m < 4; m++) begin
        r = rnd();
        bitCyc = (m == 2) ? 16'h0200 : ((p == 1) != (m == 3)) ? 16'h0080 : 16'h0040;
        nSlots = (m == 1) ? 4'h9 : 4'hA;
        apb(1'b1, `DU_OFS_CTRL0 + 12'(4 * p), {27'h0, r[8], m == 3, 1'b1, m[1:0]});
        apb(1'b1, `DU_OFS_STAT, 32'h0000_01FF);
        frQ.push_back((m == 1) ? {23'h0, 1'b1, r[7:0]} : {22'h0, 1'b1, r[8], r[7:0]});
        apb(1'b1, `DU_OFS_TXD0 + 12'(4 * p), {24'h0, r[7:0]});
        waitIrq(1'b1);
        rd(`DU_OFS_STAT, 32'h0000_003F, 32'h0000_0001 << (2 * p));
        apb(1'b1, `DU_OFS_STAT, 32'h0000_01FF);
        f = {1'b1, (m == 1) | r[16], r[15:8]};
        if (p == 0) u_host0.send(f, int'(nSlots) - 1);
        else u_host1.send(f, int'(nSlots) - 1);
        waitIrq(1'b1);
        rd(`DU_OFS_RXD0 + 12'(4 * p), 32'h0000_01FF, {23'h0, r[16] & (m != 1), r[15:8]});
      end
    end
    bitCyc = 16'h0040;
    apb(1'b1, `DU_OFS_CTRL0, 32'h0000_0005);
    apb(1'b1, `DU_OFS_STAT, 32'h0000_01FF);
    u_host0.send(10'h0FF, 9);
    waitIrq(1'b1);
    rd(`DU_OFS_STAT, 32'h0000_0030, 32'h0000_0010);
    apb(1'b1, `DU_OFS_MASK, 32'h0000_0000);
    waitIrq(1'b0);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `DU_OFS_MASK, 32'h0000_003F);
    waitIrq(1'b1);
    apb(1'b1, `DU_OFS_STAT, 32'h0000_003F);
    waitIrq(1'b0);
    chk({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, `DU_OFS_CTRL0, 32'h0000_0004);
    apb(1'b1, `DU_OFS_TXD0, 32'h0000_0055);
    repeat (30) @(posedge sys_clk);
    chk({31'h0, serialTxOut[0]}, 32'h0000_0001);
    apb(1'b1, `DU_OFS_TCON, 32'h0000_0110);
    apb(1'b1, `DU_OFS_TCNT0, 32'h0000_1234);
    apb(1'b1, `DU_OFS_CMP0, 32'h0000_1235);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, timerWaveOut[0]}, 32'h0000_0000);
    rd(`DU_OFS_TCNT0, '1, 32'h0000_1234);
    apb(1'b1, `DU_OFS_CMP0, 32'h0000_1234);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, timerWaveOut[0]}, 32'h0000_0001);
    wrapUp();
  end
endmodule : tb_dual_uart_with_baud_timers
